// ==== rtl/doze_pkg.sv ====
/*
 Doze clock control package: register offsets, field positions, reset values,
 timing constants and divisor codes shared by both ends.
 Assumes a 125 MHz system clock.
*/
`default_nettype none
package doze_pkg;
	localparam logic [7:0] OFS_CONTROL_TWO    = 8'h41;
	localparam logic [7:0] OFS_CONTROL_FIVE   = 8'h50;
	localparam logic [7:0] OFS_DOZE_EXIT      = 8'h65;
	localparam logic [7:0] OFS_CONTROL_EIGHT  = 8'h66;
	localparam logic [7:0] OFS_CONTROL_ELEVEN = 8'h79;
	// Software start enable lives in a register outside this block's table
	localparam logic [7:0] OFS_CONTROL_ONE    = 8'h40;

	localparam int TIMEOUT_LSB   = 5;
	localparam int DIVISOR_LSB   = 2;
	localparam int SW_SELECT_BIT = 0;
	localparam int START_BIT     = 3;
	localparam int SMI_EXIT_BIT  = 4;
	localparam int STOP_SEL_BIT  = 6;
	localparam int DOZE_TYPE_BIT = 5;
	localparam int SMM_EXIT_BIT  = 4;
	localparam int SW_ENABLE_BIT = 0;

	localparam logic [7:0] RESET_VALUE = 8'h00;

	// Timing: clock rate and the clock switch delay
	localparam int CLOCK_MHZ       = 125;
	localparam int SWITCH_DELAY_US = 1000;
	localparam int SWITCH_CYCLES   = SWITCH_DELAY_US * CLOCK_MHZ;
	// Oscillator tick used as timeout time base: one microsecond
	localparam int US_CYCLES       = CLOCK_MHZ;

	// Timeout periods in microseconds for codes 000..111
	localparam int TIMEOUT_US_0 = 2000;
	localparam int TIMEOUT_US_1 = 4000;
	localparam int TIMEOUT_US_2 = 8000;
	localparam int TIMEOUT_US_3 = 32000;
	localparam int TIMEOUT_US_4 = 128000;
	localparam int TIMEOUT_US_5 = 512000;
	localparam int TIMEOUT_US_6 = 2000000;
	localparam int TIMEOUT_US_7 = 8000000;

	// Divide ratios for codes 000..101; 110 and 111 reserved (treated as 1)
	localparam logic [4:0] DIV_1  = 5'h01;
	localparam logic [4:0] DIV_2  = 5'h02;
	localparam logic [4:0] DIV_4  = 5'h04;
	localparam logic [4:0] DIV_8  = 5'h08;
	localparam logic [4:0] DIV_16 = 5'h10;
	localparam logic [4:0] DIV_3  = 5'h03;
endpackage
`default_nettype wire

// ==== rtl/doze_if.sv ====
/*
 Link between the doze clock controller and the CPU side: register port,
 wake events and the clock control it receives.
 Assumes one shared clock; the testbench instantiates and joins both ends.
*/
`timescale 1ns/1ps
`default_nettype none
interface doze_if;
	logic       reg_write;   // One-cycle write strobe
	logic       reg_read;    // One-cycle read strobe
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;   // Valid cycle after reg_read
	logic       access_evt;  // Enabled access activity, pulse
	logic       smi_evt;     // SMI asserted, pulse
	logic       irq_evt;     // Enabled IRQ, pulse
	logic       in_smm;      // CPU executing in SMM, level
	logic       cpu_clk_en;  // Gate for CPU clock
	logic       sys_clk_en;  // Gate for chipset clock
	logic       doze_active; // Doze in effect, level

	modport device (input reg_write, reg_read, reg_addr, reg_wdata, access_evt,
		smi_evt, irq_evt, in_smm, output reg_rdata, cpu_clk_en, sys_clk_en,
		doze_active);
	modport host (output reg_write, reg_read, reg_addr, reg_wdata, access_evt,
		smi_evt, irq_evt, in_smm, input reg_rdata, cpu_clk_en, sys_clk_en,
		doze_active);
endinterface
`default_nettype wire

// ==== rtl/doze_clock_control.sv ====
/*
 Doze clock controller: inactivity timer, software start, clock slowing or
 stopping, and wake on access, SMI or IRQ.
 Assumes the host end drives the register port and events on the same clock.
*/
// Behaviour
// - SMM stop-clock option lets SMI wake doze
// - SMI exit bit ends doze on SMI outside SMM
// - Timeout code selects 2ms to 8s
// - Divisor code selects 1,2,4,8,16,3
// - Doze type slows or stops CPU clock
// - Select zero enables hardware inactivity timer
// - Select one: software entry only
// - Timer expiry slows CPU and chipset clocks
// - Enabled access, SMI, IRQ restore full speed
// - Host clears stop bits for slow doze
// - Host sets stop bits for stop doze
// - Writing start bit begins software doze
// - Host sets SMI exit for stop clock
// - Clock switch takes about one millisecond
// - Start bit reads timer timed-out status
// - Start honoured only when enable bit set
`timescale 1ns/1ps
`default_nettype none
module doze_clock_control #(
	// Timing counts default to the real figures; a bench may pass smaller ones
	// to keep runs short. The counters hold at most 131071 and 127.
	parameter int SWITCH_CYCLES = doze_pkg::SWITCH_CYCLES,
	parameter int US_CYCLES     = doze_pkg::US_CYCLES
) (
	input  wire logic clock,
	input  wire logic rst,
	doze_if.device    link
);
	typedef enum logic [1:0] {
		ST_FULL     = 2'b00,
		ST_ENTERING = 2'b01,
		ST_DOZE     = 2'b11,
		ST_LEAVING  = 2'b10
	} phase_t;

	typedef struct packed {
		logic [7:0]  ctl_one;
		logic [7:0]  ctl_two;
		logic [7:0]  exit_cfg;
		logic [7:0]  ctl_eight;
		logic [7:0]  ctl_eleven;
		logic [7:0]  rdata;
		logic [6:0]  us_cnt;
		logic [22:0] idle_us;
		logic        timed_out;
		phase_t      phase;
		logic [16:0] switch_cnt;
		logic [4:0]  div_cnt;
		logic        tick;
	} state_t;

	state_t s_r;
	state_t s_nxt;

	// Timeout in microseconds from the code
	function automatic logic [22:0] timeout_us(input logic [2:0] code);
		unique case (code)
			3'h0: timeout_us = 23'(doze_pkg::TIMEOUT_US_0);
			3'h1: timeout_us = 23'(doze_pkg::TIMEOUT_US_1);
			3'h2: timeout_us = 23'(doze_pkg::TIMEOUT_US_2);
			3'h3: timeout_us = 23'(doze_pkg::TIMEOUT_US_3);
			3'h4: timeout_us = 23'(doze_pkg::TIMEOUT_US_4);
			3'h5: timeout_us = 23'(doze_pkg::TIMEOUT_US_5);
			3'h6: timeout_us = 23'(doze_pkg::TIMEOUT_US_6);
			3'h7: timeout_us = 23'(doze_pkg::TIMEOUT_US_7);
		endcase
	endfunction

	// Divide ratio from the code; reserved codes run undivided
	function automatic logic [4:0] divisor(input logic [2:0] code);
		unique case (code)
			3'h0: divisor = doze_pkg::DIV_1;
			3'h1: divisor = doze_pkg::DIV_2;
			3'h2: divisor = doze_pkg::DIV_4;
			3'h3: divisor = doze_pkg::DIV_8;
			3'h4: divisor = doze_pkg::DIV_16;
			3'h5: divisor = doze_pkg::DIV_3;
			default: divisor = doze_pkg::DIV_1;
		endcase
	endfunction

	logic       wake;
	logic       hw_mode;
	logic       start_req;
	logic       stop_type;
	logic [4:0] ratio;

	// Wake qualification
	always_comb
	begin
		hw_mode   = ~s_r.ctl_two[doze_pkg::SW_SELECT_BIT];
		stop_type = s_r.ctl_eight[doze_pkg::DOZE_TYPE_BIT];
		ratio     = divisor(s_r.ctl_two[doze_pkg::DIVISOR_LSB +: 3]);
		// In SMM the ordinary SMI exit is masked; only the SMM option helps
		wake = link.access_evt | link.irq_evt
			| (link.smi_evt & ~link.in_smm & s_r.exit_cfg[doze_pkg::SMI_EXIT_BIT])
			| (link.smi_evt & link.in_smm & stop_type
				& s_r.ctl_eleven[doze_pkg::SMM_EXIT_BIT]);
		start_req = link.reg_write && link.reg_addr == doze_pkg::OFS_CONTROL_FIVE
			&& link.reg_wdata[doze_pkg::START_BIT]
			&& s_r.ctl_one[doze_pkg::SW_ENABLE_BIT];
	end

	// Next-state logic
	always_comb
	begin
		s_nxt = s_r;
		// Register writes; start bit is a strobe, not stored
		if (link.reg_write)
		begin
			unique case (link.reg_addr)
				doze_pkg::OFS_CONTROL_ONE:    s_nxt.ctl_one    = link.reg_wdata;
				doze_pkg::OFS_CONTROL_TWO:    s_nxt.ctl_two    = link.reg_wdata;
				doze_pkg::OFS_DOZE_EXIT:      s_nxt.exit_cfg   = link.reg_wdata;
				doze_pkg::OFS_CONTROL_EIGHT:  s_nxt.ctl_eight  = link.reg_wdata;
				doze_pkg::OFS_CONTROL_ELEVEN: s_nxt.ctl_eleven = link.reg_wdata;
				default: ;
			endcase
		end
		// Register reads, one cycle latency; unmapped reads zero
		s_nxt.rdata = 8'h00;
		if (link.reg_read)
		begin
			unique case (link.reg_addr)
				doze_pkg::OFS_CONTROL_ONE:    s_nxt.rdata = s_r.ctl_one;
				doze_pkg::OFS_CONTROL_TWO:    s_nxt.rdata = s_r.ctl_two;
				doze_pkg::OFS_CONTROL_FIVE:
					s_nxt.rdata = 8'(s_r.timed_out) << doze_pkg::START_BIT;
				doze_pkg::OFS_DOZE_EXIT:      s_nxt.rdata = s_r.exit_cfg;
				doze_pkg::OFS_CONTROL_EIGHT:  s_nxt.rdata = s_r.ctl_eight;
				doze_pkg::OFS_CONTROL_ELEVEN: s_nxt.rdata = s_r.ctl_eleven;
				default: ;
			endcase
		end
		// Microsecond time base for the inactivity timer
		s_nxt.tick = 1'b0;
		if (s_r.us_cnt == 7'(US_CYCLES - 1))
		begin
			s_nxt.us_cnt = 7'h00;
			s_nxt.tick   = 1'b1;
		end
		else
			s_nxt.us_cnt = s_r.us_cnt + 7'h01;
		// Inactivity timer; events reload it, expiry latches status
		if (!hw_mode || wake)
		begin
			s_nxt.idle_us   = 23'h000000;
			s_nxt.timed_out = 1'b0;
		end
		else if (s_r.tick && !s_r.timed_out)
		begin
			if (s_r.idle_us + 23'h000001
				>= timeout_us(s_r.ctl_two[doze_pkg::TIMEOUT_LSB +: 3]))
				s_nxt.timed_out = 1'b1;
			else
				s_nxt.idle_us = s_r.idle_us + 23'h000001;
		end
		// Doze phases with the clock switch delay on entry and exit; a wake while entering returns at once
		unique case (s_r.phase)
			ST_FULL:
			if (!wake && ((hw_mode && s_nxt.timed_out && !s_r.timed_out) || start_req))
			begin
				s_nxt.phase      = ST_ENTERING;
				s_nxt.switch_cnt = 17'(SWITCH_CYCLES - 1);
			end
			ST_ENTERING:
			if (wake)
				s_nxt.phase = ST_FULL;
			else if (s_r.switch_cnt == 17'h00000)
				s_nxt.phase = ST_DOZE;
			else
				s_nxt.switch_cnt = s_r.switch_cnt - 17'h00001;
			ST_DOZE:
			if (wake)
			begin
				s_nxt.phase      = ST_LEAVING;
				s_nxt.switch_cnt = 17'(SWITCH_CYCLES - 1);
			end
			ST_LEAVING:
			if (s_r.switch_cnt == 17'h00000)
				s_nxt.phase = ST_FULL;
			else
				s_nxt.switch_cnt = s_r.switch_cnt - 17'h00001;
		endcase
		// Divider producing the slowed clock enable
		if (s_r.div_cnt + 5'h01 >= ratio)
			s_nxt.div_cnt = 5'h00;
		else
			s_nxt.div_cnt = s_r.div_cnt + 5'h01;
	end

	// State register
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			s_r       <= '0;
			s_r.phase <= ST_FULL;
		end
		else
			s_r <= s_nxt;
	end

	// Clock gating outputs: chipset always slowed, CPU slowed or stopped
	assign link.doze_active = (s_r.phase == ST_DOZE);
	assign link.sys_clk_en  = !link.doze_active || s_r.div_cnt == 5'h00;
	assign link.cpu_clk_en  = !link.doze_active
		|| (!stop_type && s_r.div_cnt == 5'h00);
	assign link.reg_rdata   = s_r.rdata;
endmodule
`default_nettype wire

// ==== rtl/doze_host_end.sv ====
/*
 Host end of the doze link: turns plain user requests into register
 accesses and forwards wake events.
 Assumes the device end is joined through doze_if on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module doze_host_end (
	input  wire logic       clock,
	input  wire logic       rst,
	doze_if.host            link,
	input  wire logic       req_write,
	input  wire logic       req_read,
	input  wire logic [7:0] req_addr,
	input  wire logic [7:0] req_wdata,
	input  wire logic       req_slow_doze,
	input  wire logic       req_stop_doze,
	input  wire logic       ev_access,
	input  wire logic       ev_smi,
	input  wire logic       ev_irq,
	input  wire logic       ev_in_smm,
	output logic      [7:0] rsp_rdata,
	output logic            rsp_valid,
	output logic            busy,
	output logic            doze_seen
);
	typedef enum logic [2:0] {
		H_IDLE  = 3'b000,
		H_EXIT  = 3'b001,
		H_TYPE  = 3'b011,
		H_START = 3'b010
	} hstate_t;

	typedef struct packed {
		hstate_t    st;
		logic       stop;
		logic       rd_pend;
		logic [7:0] rdata;
		logic       valid;
	} hreg_t;

	hreg_t h_r;
	hreg_t h_nxt;

	// Sequencer: exit config, type, then start
	always_comb
	begin
		h_nxt       = h_r;
		h_nxt.valid = 1'b0;
		h_nxt.rd_pend = 1'b0;
		link.reg_write = 1'b0;
		link.reg_read  = 1'b0;
		link.reg_addr  = 8'h00;
		link.reg_wdata = 8'h00;
		unique case (h_r.st)
			H_IDLE:
			if (req_slow_doze || req_stop_doze)
			begin
				h_nxt.stop = req_stop_doze;
				h_nxt.st   = H_EXIT;
			end
			else if (req_write || req_read)
			begin
				link.reg_write = req_write;
				link.reg_read  = req_read && !req_write;
				link.reg_addr  = req_addr;
				link.reg_wdata = req_wdata;
				h_nxt.rd_pend  = req_read && !req_write;
			end
			H_EXIT:
			begin
				// Stop doze also needs SMI exit so a pending SMI is serviced
				link.reg_write = 1'b1;
				link.reg_addr  = doze_pkg::OFS_DOZE_EXIT;
				link.reg_wdata = h_r.stop
					? 8'h50 : 8'h10;
				h_nxt.st = H_TYPE;
			end
			H_TYPE:
			begin
				link.reg_write = 1'b1;
				link.reg_addr  = doze_pkg::OFS_CONTROL_EIGHT;
				link.reg_wdata = 8'(h_r.stop) << doze_pkg::DOZE_TYPE_BIT;
				h_nxt.st = H_START;
			end
			H_START:
			begin
				link.reg_write = 1'b1;
				link.reg_addr  = doze_pkg::OFS_CONTROL_FIVE;
				link.reg_wdata = 8'h01 << doze_pkg::START_BIT;
				h_nxt.st = H_IDLE;
			end
			default: h_nxt.st = H_IDLE;
		endcase
		if (h_r.rd_pend)
		begin
			h_nxt.rdata = link.reg_rdata;
			h_nxt.valid = 1'b1;
		end
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			h_r    <= '0;
			h_r.st <= H_IDLE;
		end
		else
			h_r <= h_nxt;
	end

	// Events pass straight through; same clock domain
	assign link.access_evt = ev_access;
	assign link.smi_evt    = ev_smi;
	assign link.irq_evt    = ev_irq;
	assign link.in_smm     = ev_in_smm;
	assign rsp_rdata       = h_r.rdata;
	assign rsp_valid       = h_r.valid;
	assign busy            = (h_r.st != H_IDLE);
	assign doze_seen       = link.doze_active;
endmodule
`default_nettype wire

// ==== test/doze_clock_control_sva.sv ====
/*
 Checker for the doze link: register readback, clock gating and wake.
 Assumes one clock; the bench instantiates it beside the interface.
*/
`timescale 1ns/1ps
`default_nettype none
module doze_checker (
	input wire logic       clock,
	input wire logic       rst,
	input wire logic       reg_write,
	input wire logic       reg_read,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic       access_evt,
	input wire logic       smi_evt,
	input wire logic       irq_evt,
	input wire logic       in_smm,
	input wire logic       cpu_clk_en,
	input wire logic       sys_clk_en,
	input wire logic       doze_active
);
	typedef struct packed {
		logic [7:0] two;
		logic [7:0] exit_cfg;
		logic [7:0] eight;
		logic [7:0] eleven;
	} shadow_t;
	shadow_t shadow_r;
	shadow_t shadow_nxt;

	// Shadow of written settings, so readback and wake rules can be judged
	always_comb
	begin
		shadow_nxt = shadow_r;
		if (reg_write && reg_addr == doze_pkg::OFS_CONTROL_TWO)
			shadow_nxt.two = reg_wdata;
		if (reg_write && reg_addr == doze_pkg::OFS_DOZE_EXIT)
			shadow_nxt.exit_cfg = reg_wdata;
		if (reg_write && reg_addr == doze_pkg::OFS_CONTROL_EIGHT)
			shadow_nxt.eight = reg_wdata;
		if (reg_write && reg_addr == doze_pkg::OFS_CONTROL_ELEVEN)
			shadow_nxt.eleven = reg_wdata;
		if (rst)
			shadow_nxt = '0;
	end
	always_ff @(posedge clock)
		shadow_r <= shadow_nxt;

	default clocking @(posedge clock); endclocking
	default disable iff (rst);

	// Readback of the timeout and divisor register and of the doze type register follows the last write
	control_two_a: assert property (reg_read && reg_addr == doze_pkg::OFS_CONTROL_TWO
		|=> reg_rdata == shadow_r.two) else $error("control two readback wrong");
	type_reg_a: assert property (reg_read && reg_addr == doze_pkg::OFS_CONTROL_EIGHT
		|=> reg_rdata == shadow_r.eight) else $error("doze type readback wrong");
	// Timer disabled means the status bit cannot report a timeout
	status_sw_a: assert property (reg_read && reg_addr == doze_pkg::OFS_CONTROL_FIVE
		&& shadow_r.two[0] |=> !reg_rdata[3]) else $error("status set with timer off");
	wake_ends_a: assert property (doze_active && (access_evt || irq_evt)
		|=> !doze_active) else $error("access or irq did not end doze");
	smi_exit_a: assert property (doze_active && smi_evt && !in_smm
		&& shadow_r.exit_cfg[4] |=> !doze_active) else $error("smi did not end doze");
	smm_exit_a: assert property (doze_active && smi_evt && in_smm && shadow_r.eight[5]
		&& shadow_r.eleven[4] |=> !doze_active) else $error("smi in smm did not end doze");
	smi_slow_a: assert property (doze_active && smi_evt && !in_smm && !access_evt
		&& !irq_evt && !shadow_r.exit_cfg[4] |=> doze_active) else $error("smi ended doze");
	stop_type_a: assert property (doze_active && shadow_r.eight[5]
		|-> !cpu_clk_en) else $error("cpu clock runs in stop doze");
	// Divide by two never gives two enables in a row while dozing
	div_two_a: assert property (doze_active && shadow_r.two[4:2] == 3'h1 && sys_clk_en
		|=> !sys_clk_en || !doze_active) else $error("divide by two broken");

	cover property ($rose(doze_active));
	cover property (doze_active && smi_evt && in_smm);
	cover property (reg_read && reg_addr == doze_pkg::OFS_CONTROL_FIVE);
	cover property (doze_active && !shadow_r.eight[5]);
endmodule
`default_nettype wire

// ==== test/doze_clock_control_test.sv ====
/*
 Bench for both doze link ends: register access, software and hardware doze, wake.
 Assumes a 125 MHz clock; timing counts are shortened at the instance.
*/
`timescale 1ns/1ps
`default_nettype none
module doze_clock_control_test;
	logic       clock = 1'b0;
	logic       rst = 1'b1;
	logic       req_write = 1'b0;
	logic       req_read = 1'b0;
	logic [7:0] req_addr = 8'h00;
	logic [7:0] req_wdata = 8'h00;
	logic       req_slow_doze = 1'b0;
	logic       req_stop_doze = 1'b0;
	logic       ev_access = 1'b0;
	logic       ev_smi = 1'b0;
	logic       ev_irq = 1'b0;
	logic       ev_in_smm = 1'b0;
	logic [7:0] rsp_rdata;
	logic       rsp_valid;
	logic       busy;
	logic       doze_seen;
	int         err_total = 0;
	int         n_checks = 0;

	// Shortened counts: the real ones would need over a hundred thousand cycles per clock switch
	localparam int SW_CYC = 200;
	localparam int US_CYC = 2;
	localparam int HW_CYC = doze_pkg::TIMEOUT_US_0 * US_CYC + SW_CYC;

	always #4 clock = ~clock;

	doze_if link();
	doze_clock_control #(.SWITCH_CYCLES(SW_CYC), .US_CYCLES(US_CYC)) i_doze_clock_control (
		.clock(clock), .rst(rst), .link(link.device));
	doze_host_end i_doze_host_end (.clock(clock), .rst(rst), .link(link.host),
		.req_write(req_write), .req_read(req_read), .req_addr(req_addr),
		.req_wdata(req_wdata), .req_slow_doze(req_slow_doze), .req_stop_doze(req_stop_doze),
		.ev_access(ev_access), .ev_smi(ev_smi), .ev_irq(ev_irq), .ev_in_smm(ev_in_smm),
		.rsp_rdata(rsp_rdata), .rsp_valid(rsp_valid), .busy(busy), .doze_seen(doze_seen));
	doze_checker i_doze_checker (.clock(clock), .rst(rst), .reg_write(link.reg_write),
		.reg_read(link.reg_read), .reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata),
		.reg_rdata(link.reg_rdata), .access_evt(link.access_evt), .smi_evt(link.smi_evt),
		.irq_evt(link.irq_evt), .in_smm(link.in_smm), .cpu_clk_en(link.cpu_clk_en),
		.sys_clk_en(link.sys_clk_en), .doze_active(link.doze_active));

	task check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp)
		begin
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
			err_total++;
		end
	endtask

	task check_bit(input string what, input logic exp, input logic got);
		check_byte(what, {7'h00, exp}, {7'h00, got});
	endtask

	task finish_test;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// One write cycle through the host end
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		req_write <= 1'b1;
		req_addr <= a;
		req_wdata <= d;
		@(posedge clock);
		req_write <= 1'b0;
	endtask

	// Read and compare; the answer is awaited under a bound
	task rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
		int n;
		@(posedge clock);
		req_read <= 1'b1;
		req_addr <= a;
		@(posedge clock);
		req_read <= 1'b0;
		n = 0;
		do
		begin
			@(posedge clock);
			#1;
			n++;
		end while (rsp_valid !== 1'b1 && n < 8);
		check_bit("rsp_valid", 1'b1, rsp_valid);
		check_byte(what, exp, rsp_rdata);
	endtask

	task pulse_smi(input logic smm);
		@(posedge clock);
		ev_smi <= 1'b1;
		ev_in_smm <= smm;
		@(posedge clock);
		ev_smi <= 1'b0;
		repeat (2) @(posedge clock);
		#1;
	endtask

	// Wait for doze to take effect, counting edges; bounded
	task wait_doze(input int limit, output int n);
		n = 0;
		while (doze_seen !== 1'b1 && n < limit)
		begin
			@(posedge clock);
			#1;
			n++;
		end
	endtask

	// Count clock enables over a span while dozing
	task count_en(input int span, output logic [7:0] sys_n, output logic [7:0] cpu_n);
		sys_n = 8'h00;
		cpu_n = 8'h00;
		for (int i = 0; i < span; i++)
		begin
			@(posedge clock);
			#1;
			sys_n = sys_n + {7'h00, link.sys_clk_en};
			cpu_n = cpu_n + {7'h00, link.cpu_clk_en};
		end
	endtask

	// Every register but control one reads zero after reset; an unmapped place reads zero
	task t_reset_values;
		logic [7:0] ofs [6];
		ofs = '{8'h41, 8'h50, 8'h65, 8'h66, 8'h79, 8'h3C};
		foreach (ofs[i])
			rd_chk("reset value", ofs[i], 8'h00);
	endtask

	// Readback, then a slow doze request that lacks the start enable
	task t_config_refused;
		wr(8'h41, 8'hA4);
		rd_chk("control two", 8'h41, 8'hA4);
		wr(8'h41, 8'h05);
		rd_chk("status sw", 8'h50, 8'h00);
		@(posedge clock);
		req_slow_doze <= 1'b1;
		@(posedge clock);
		req_slow_doze <= 1'b0;
		#1;
		check_bit("busy", 1'b1, busy);
		// Long enough that an accepted start would have reached doze
		repeat (SW_CYC + 20) @(posedge clock);
		check_bit("busy done", 1'b0, busy);
		rd_chk("exit slow", 8'h65, 8'h10);
		rd_chk("type slow", 8'h66, 8'h00);
		check_bit("no doze", 1'b0, doze_seen);
	endtask

	// Stop doze: entry delay, gating, then wake from inside SMM
	task t_stop_doze;
		int         n;
		logic [7:0] sys_n;
		logic [7:0] cpu_n;
		wr(8'h40, 8'h01);
		@(posedge clock);
		req_stop_doze <= 1'b1;
		@(posedge clock);
		req_stop_doze <= 1'b0;
		// Three host writes, then the switch delay
		wait_doze(SW_CYC + 100, n);
		check_bit("entry delay", 1'b1, n == SW_CYC + 3);
		count_en(16, sys_n, cpu_n);
		check_byte("sys pulses", 8'h08, sys_n);
		check_byte("cpu pulses", 8'h00, cpu_n);
		rd_chk("type stop", 8'h66, 8'h20);
		wr(8'h79, 8'h00);
		pulse_smi(1'b1);
		check_bit("smm no exit", 1'b1, doze_seen);
		wr(8'h79, 8'h10);
		pulse_smi(1'b1);
		check_bit("smm exit", 1'b0, doze_seen);
		@(posedge clock);
		ev_in_smm <= 1'b0;
		repeat (SW_CYC + 4) @(posedge clock);
	endtask

	// Hardware doze: an access reloads the timer, expiry slows both clocks,
	// and an SMI outside SMM ends doze only with the exit bit set
	task t_hw_doze;
		int         n;
		logic [7:0] sys_n;
		logic [7:0] cpu_n;
		wr(8'h66, 8'h00);
		wr(8'h65, 8'h00);
		wr(8'h41, 8'h0C);
		rd_chk("status counting", 8'h50, 8'h00);
		repeat (1000) @(posedge clock);
		@(posedge clock);
		ev_access <= 1'b1;
		@(posedge clock);
		ev_access <= 1'b0;
		// Without the reload doze would come about 1000 cycles early
		wait_doze(HW_CYC + 100, n);
		check_bit("hw entry", 1'b1, n >= HW_CYC - 4 && n <= HW_CYC + 4);
		rd_chk("status hw", 8'h50, 8'h08);
		count_en(16, sys_n, cpu_n);
		check_byte("hw sys pulses", 8'h02, sys_n);
		check_byte("hw cpu pulses", 8'h02, cpu_n);
		pulse_smi(1'b0);
		check_bit("smi slow", 1'b1, doze_seen);
		wr(8'h65, 8'h10);
		pulse_smi(1'b0);
		check_bit("smi exit", 1'b0, doze_seen);
		repeat (SW_CYC + 4) @(posedge clock);
	endtask

	// Software slow doze at divide by three, ended by an IRQ
	task t_slow_doze;
		int         n;
		logic [7:0] sys_n;
		logic [7:0] cpu_n;
		wr(8'h41, 8'h15);
		@(posedge clock);
		req_slow_doze <= 1'b1;
		@(posedge clock);
		req_slow_doze <= 1'b0;
		wait_doze(SW_CYC + 100, n);
		check_bit("slow entry", 1'b1, n == SW_CYC + 3);
		count_en(15, sys_n, cpu_n);
		check_byte("slow sys pulses", 8'h05, sys_n);
		check_byte("slow cpu pulses", 8'h05, cpu_n);
		@(posedge clock);
		ev_irq <= 1'b1;
		@(posedge clock);
		ev_irq <= 1'b0;
		#1;
		check_bit("irq wake", 1'b0, doze_seen);
	endtask

	// Watchdog against a hang
	initial
	begin
		repeat (20000) @(posedge clock);
		err_total++;
		finish_test();
	end

	initial
	begin
		repeat (4) @(posedge clock);
		rst <= 1'b0;
		t_reset_values();
		t_config_refused();
		t_stop_doze();
		t_hw_doze();
		t_slow_doze();
		finish_test();
	end
endmodule
`default_nettype wire
